// File: core/tmma_div_if.sv
// Interface: start/done handshake between the unit and its divider
`timescale 1ns/1ps
interface tmma_div_if;
    logic start;
    logic [tmma_pkg::SUM_W-1:0] dividend;
    logic [6:0] divisor;
    logic done;
    logic [tmma_pkg::DATA_W-1:0] quotient;
    modport master (output start, output dividend, output divisor, input done, input quotient);
    modport slave (input start, input dividend, input divisor, output done, output quotient);
endinterface

// File: core/tmma_divider.sv
// Sequential signed divider, truncating toward zero
`timescale 1ns/1ps
module tmma_divider (
    input wire logic clk,
    input wire logic rst,
    tmma_div_if.slave div
);
    localparam int W = tmma_pkg::SUM_W;
    logic [W-1:0] mag_reg, mag_next;
    logic [W-1:0] rem_reg, rem_next;
    logic neg_reg, neg_next;
    logic [5:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [W-1:0] q_reg, q_next;

    // Restoring division on magnitudes; sign applied at the end
    always_comb begin
        logic [W-1:0] trial;
        trial = '0;
        mag_next = mag_reg;
        rem_next = rem_reg;
        neg_next = neg_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        q_next = q_reg;
        if (div.start && !busy_reg) begin
            neg_next = div.dividend[W-1];
            mag_next = div.dividend[W-1] ? W'(-div.dividend) : div.dividend;
            rem_next = '0;
            cnt_next = 6'(W);
            busy_next = 1'b1;
        end else if (busy_reg) begin
            trial = {rem_reg[W-2:0], mag_reg[W-1]};
            mag_next = {mag_reg[W-2:0], 1'b0};
            if (trial >= W'(div.divisor)) begin
                rem_next = trial - W'(div.divisor);
                mag_next[0] = 1'b1;
            end else begin
                rem_next = trial;
            end
            cnt_next = cnt_reg - 6'h01;
            if (cnt_reg == 6'h01) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                q_next = neg_reg ? W'(-mag_next) : mag_next;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mag_reg <= '0;
            rem_reg <= '0;
            neg_reg <= 1'b0;
            cnt_reg <= 6'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            q_reg <= '0;
        end else begin
            mag_reg <= mag_next;
            rem_reg <= rem_next;
            neg_reg <= neg_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            q_reg <= q_next;
        end
    end

    assign div.done = done_reg;
    assign div.quotient = q_reg[tmma_pkg::DATA_W-1:0];
endmodule

// File: core/tmma_pkg.sv
// Package: shared constants and types for the table statistics unit
package tmma_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int LEN_W = 7;
    localparam int SUM_W = DATA_W + 6;
    localparam logic [LEN_W-1:0] LEN_MIN = 7'h01;
    localparam logic [LEN_W-1:0] LEN_MAX = 7'h40;
    localparam logic [ADDR_W-1:0] POS_SLOT = 16'h0001;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [SUM_W-1:0] SUM_RST = 22'h000000;
    localparam int DIV_CYCLES = SUM_W;
    typedef enum logic [1:0] {
        TMMA_OP_MIN,
        TMMA_OP_MAX,
        TMMA_OP_MEAN
    } tmma_op_t;
endpackage

// File: core/tmma_unit.sv
// Table minimum / maximum / mean unit for the instruction sequencer
//
// Behaviour
// - min op scans n signed words from base, writes smallest to destination.
// - min op writes position of smallest to destination plus one.
// - tied minimum entries report the lowest position.
// - execution output goes active the cycle after the min position write.
// - enable low while idle: no operation, no writes, execution output low.
// - min entries are full-range two's-complement 16-bit values.
// - mean op writes arithmetic mean of n words then asserts output.
// - mean entries are signed 16-bit words.
// - max op writes largest to destination, position to next, asserts output.
// - tied maximum entries report the lowest position.
`timescale 1ns/1ps
module tmma_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire tmma_pkg::tmma_op_t op,
    input wire logic [tmma_pkg::ADDR_W-1:0] src_base,
    input wire logic [tmma_pkg::ADDR_W-1:0] dst_base,
    input wire logic [tmma_pkg::LEN_W-1:0] table_len,
    output logic rd_req,
    output logic [tmma_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [tmma_pkg::DATA_W-1:0] rd_data,
    output logic wr_en,
    output logic [tmma_pkg::ADDR_W-1:0] wr_addr,
    output logic [tmma_pkg::DATA_W-1:0] wr_data,
    output logic exec_out
);
    typedef enum {ST_IDLE, ST_READ, ST_WAIT, ST_DIV, ST_WVAL, ST_WPOS, ST_DONE} tmma_state_t;
    localparam int DW = tmma_pkg::DATA_W;
    localparam int AW = tmma_pkg::ADDR_W;
    localparam int LW = tmma_pkg::LEN_W;
    localparam int SW = tmma_pkg::SUM_W;

    tmma_state_t state_reg, state_next;
    tmma_pkg::tmma_op_t op_reg, op_next;
    logic [AW-1:0] src_reg, src_next, dst_reg, dst_next;
    logic [LW-1:0] len_reg, len_next, idx_reg, idx_next;
    logic [DW-1:0] best_reg, best_next;
    logic [LW-1:0] pos_reg, pos_next;
    logic [SW-1:0] sum_reg, sum_next;
    logic rd_req_reg, rd_req_next;
    logic [AW-1:0] rd_addr_reg, rd_addr_next;
    logic wr_en_reg, wr_en_next;
    logic [AW-1:0] wr_addr_reg, wr_addr_next;
    logic [DW-1:0] wr_data_reg, wr_data_next;
    logic exec_reg, exec_next;

    tmma_div_if div ();

    tmma_divider u_div (
        .clk(clk),
        .rst(rst),
        .div(div)
    );

    // Strict compare keeps the first of equal entries
    function automatic logic better(input tmma_pkg::tmma_op_t o, input logic [DW-1:0] a,
                                    input logic [DW-1:0] b);
        if (o == tmma_pkg::TMMA_OP_MAX)
            return $signed(a) > $signed(b);
        return $signed(a) < $signed(b);
    endfunction

    assign div.start = (state_reg == ST_DIV) && (idx_reg == '0);
    assign div.dividend = sum_reg;
    assign div.divisor = len_reg;

    // Sequencer: one read per entry, one cycle read latency
    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        src_next = src_reg;
        dst_next = dst_reg;
        len_next = len_reg;
        idx_next = idx_reg;
        best_next = best_reg;
        pos_next = pos_reg;
        sum_next = sum_reg;
        rd_req_next = 1'b0;
        rd_addr_next = rd_addr_reg;
        wr_en_next = 1'b0;
        wr_addr_next = wr_addr_reg;
        wr_data_next = wr_data_reg;
        exec_next = exec_reg;
        case (state_reg)
            ST_IDLE: begin
                if (enable) begin
                    op_next = op;
                    src_next = src_base;
                    dst_next = dst_base;
                    // Lengths outside 1..64 are clamped; issuer must not send them
                    len_next = (table_len == '0) ? tmma_pkg::LEN_MIN :
                        (table_len > tmma_pkg::LEN_MAX) ? tmma_pkg::LEN_MAX : table_len;
                    idx_next = '0;
                    sum_next = tmma_pkg::SUM_RST;
                    state_next = ST_READ;
                end else begin
                    exec_next = 1'b0;
                end
            end
            ST_READ: begin
                rd_req_next = 1'b1;
                rd_addr_next = src_reg + AW'(idx_reg);
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                if (!rd_req_reg) begin
                    // Sign-extend: full signed range kept exactly
                    sum_next = sum_reg + SW'($signed(rd_data));
                    if (idx_reg == '0 || better(op_reg, rd_data, best_reg)) begin
                        best_next = rd_data;
                        pos_next = idx_reg;
                    end
                    idx_next = idx_reg + LW'(1);
                    if (idx_reg + LW'(1) == len_reg) begin
                        idx_next = '0;
                        state_next = (op_reg == tmma_pkg::TMMA_OP_MEAN) ? ST_DIV : ST_WVAL;
                    end else begin
                        state_next = ST_READ;
                    end
                end
            end
            ST_DIV: begin
                idx_next = LW'(1);
                if (div.done) begin
                    best_next = div.quotient;
                    state_next = ST_WVAL;
                end
            end
            ST_WVAL: begin
                wr_en_next = 1'b1;
                wr_addr_next = dst_reg;
                wr_data_next = best_reg;
                state_next = (op_reg == tmma_pkg::TMMA_OP_MEAN) ? ST_DONE : ST_WPOS;
            end
            ST_WPOS: begin
                wr_en_next = 1'b1;
                wr_addr_next = dst_reg + tmma_pkg::POS_SLOT;
                wr_data_next = DW'(pos_reg);
                state_next = ST_DONE;
            end
            ST_DONE: begin
                exec_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Register all state and outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            op_reg <= tmma_pkg::TMMA_OP_MIN;
            src_reg <= '0;
            dst_reg <= '0;
            len_reg <= tmma_pkg::LEN_MIN;
            idx_reg <= '0;
            best_reg <= tmma_pkg::DATA_RST;
            pos_reg <= '0;
            sum_reg <= tmma_pkg::SUM_RST;
            rd_req_reg <= 1'b0;
            rd_addr_reg <= '0;
            wr_en_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= tmma_pkg::DATA_RST;
            exec_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            src_reg <= src_next;
            dst_reg <= dst_next;
            len_reg <= len_next;
            idx_reg <= idx_next;
            best_reg <= best_next;
            pos_reg <= pos_next;
            sum_reg <= sum_next;
            rd_req_reg <= rd_req_next;
            rd_addr_reg <= rd_addr_next;
            wr_en_reg <= wr_en_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
            exec_reg <= exec_next;
        end
    end

    assign rd_req = rd_req_reg;
    assign rd_addr = rd_addr_reg;
    assign wr_en = wr_en_reg;
    assign wr_addr = wr_addr_reg;
    assign wr_data = wr_data_reg;
    assign exec_out = exec_reg;

    // Checks on the sequencer outputs
    chk_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_IDLE && !enable) |=> !exec_out && !wr_en)
        else $error("exec or write while disabled");
    chk_pos_after_val: assert property (@(posedge clk) disable iff (rst)
        (wr_en && op_reg != tmma_pkg::TMMA_OP_MEAN && state_reg == ST_WPOS)
        |=> wr_en && wr_addr == $past(wr_addr) + tmma_pkg::POS_SLOT)
        else $error("position not written to next slot");
    // Last result write always sits in the cycle just before exec rises, for every op
    chk_exec_after_write: assert property (@(posedge clk) disable iff (rst)
        $rose(exec_out) |-> $past(wr_en))
        else $error("exec without result write");
    chk_read_in_table: assert property (@(posedge clk) disable iff (rst)
        rd_req |-> (rd_addr - src_reg) < AW'(len_reg))
        else $error("read outside table");
    chk_pos_in_table: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_WPOS) |-> pos_reg < len_reg)
        else $error("position outside table");
    chk_best_ties: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_WAIT && !rd_req_reg && idx_reg != '0 && rd_data == best_reg)
        |=> pos_reg == $past(pos_reg))
        else $error("tie moved position");
    chk_max_order: assert property (@(posedge clk) disable iff (rst)
        // First entry reloads best, so it may legally drop below an older result
        (state_reg == ST_WAIT && !rd_req_reg && op_reg == tmma_pkg::TMMA_OP_MAX
            && idx_reg != '0)
        |=> !($signed(best_reg) < $signed($past(best_reg))))
        else $error("max decreased");
    chk_div_bounded: assert property (@(posedge clk) disable iff (rst)
        div.start |-> ##[1:30] div.done)
        else $error("divider late");
    chk_mean_one_write: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_WVAL && op_reg == tmma_pkg::TMMA_OP_MEAN) |=> ##1 !wr_en)
        else $error("mean wrote twice");
    cov_min: cover property (@(posedge clk) state_reg == ST_WPOS && op_reg == tmma_pkg::TMMA_OP_MIN);
    cov_max: cover property (@(posedge clk) state_reg == ST_WPOS && op_reg == tmma_pkg::TMMA_OP_MAX);
    cov_mean: cover property (@(posedge clk) div.done);
    cov_disabled: cover property (@(posedge clk) $fell(exec_out));
endmodule

// File: dv/testbench.sv
// Self-checking bench for the table minimum / maximum / mean unit
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rst;
    logic enable;
    tmma_pkg::tmma_op_t op;
    logic [15:0] src_base;
    logic [15:0] dst_base;
    logic [6:0] table_len;
    logic rd_req;
    logic [15:0] rd_addr;
    logic [15:0] rd_data;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic exec_out;
    int bad_count;
    int n_tests;
    int seed;
    int cycles;
    int wr_seen;
    int tbl [0:63];

    tmma_unit tmma_unit_inst (.clk(clk), .rst(rst), .enable(enable), .op(op),
        .src_base(src_base), .dst_base(dst_base), .table_len(table_len),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .exec_out(exec_out));
    tmma_regmem tmma_regmem_inst (.clk(clk), .rst(rst), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard and write counter; a run needs well under 10K cycles
    always @(posedge clk) begin
        cycles++;
        if (wr_en === 1'b1) begin
            wr_seen++;
        end
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    // Expected result: strict compare keeps the lowest index on ties
    function automatic void model(input int k, input int n, output int v, output int p);
        int s;
        v = tbl[0];
        p = 0;
        s = 0;
        for (int i = 0; i < n; i++) begin
            s += tbl[i];
            if ((k == 0 && tbl[i] < v) || (k == 1 && tbl[i] > v)) begin
                v = tbl[i];
                p = i;
            end
        end
        if (k == 2) begin
            v = s / n;
        end
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // One whole instruction: preload, enable, wait, drop enable, check
    task automatic run_op(input int k, input int n, input int src, input int dst);
        int v;
        int p;
        int w;
        model(k, n, v, p);
        for (int i = 0; i < n; i++) begin
            tmma_regmem_inst.mem[src + i] = 16'(tbl[i]);
        end
        tmma_regmem_inst.mem[dst] = 16'h5a5a;
        tmma_regmem_inst.mem[dst + 1] = 16'h5a5a;
        @(negedge clk);
        op = tmma_pkg::tmma_op_t'(k);
        src_base = 16'(src);
        dst_base = 16'(dst);
        table_len = 7'(n);
        enable = 1'b1;
        wr_seen = 0;
        w = 0;
        while (exec_out !== 1'b1 && w < 400) begin
            @(negedge clk);
            w++;
        end
        enable = 1'b0;
        check("exec_out", 16'(exec_out), 16'h0001);
        check("write_count", 16'(wr_seen), (k == 2) ? 16'h0001 : 16'h0002);
        check("result", tmma_regmem_inst.mem[dst], 16'(v));
        check("position", tmma_regmem_inst.mem[dst + 1], (k == 2) ? 16'h5a5a : 16'(p));
        repeat (3) @(negedge clk);
        check("exec_off", 16'(exec_out), 16'h0000);
        w = wr_seen;
        repeat (6) @(negedge clk);
        check("idle_writes", 16'(wr_seen - w), 16'h0000);
        $display("test op %0d len %0d done", k, n);
    endtask

    initial begin
        seed = 13;
        bad_count = 0;
        n_tests = 0;
        cycles = 0;
        wr_seen = 0;
        rst = 1'b1;
        enable = 1'b0;
        op = tmma_pkg::TMMA_OP_MIN;
        src_base = 16'h0000;
        dst_base = 16'h0000;
        table_len = 7'h01;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        check("disabled_exec", 16'(exec_out), 16'h0000);
        check("disabled_writes", 16'(wr_seen), 16'h0000);
        // Ten entries with tied extremes at 2/4 and 7/9, mean 200
        for (int i = 0; i < 10; i++) begin
            tbl[i] = (i == 2 || i == 4) ? -10000 : ((i == 7 || i == 9) ? 20000 : -3000);
        end
        for (int k = 0; k < 3; k++) begin
            run_op(k, 10, 100, 200);
        end
        // Full-length tables at both ends of the signed range
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 64; i++) begin
                tbl[i] = e ? 32767 : -32768;
            end
            for (int k = 0; k < 3; k++) begin
                run_op(k, 64, 300, 900);
            end
        end
        // Negative mean must truncate toward zero, not down
        tbl[0] = -1;
        tbl[1] = -1;
        tbl[2] = 0;
        run_op(2, 3, 10, 950);
        run_op(1, 1, 12, 960);
        // Random tables; odd passes use a narrow range to force ties
        for (int r = 0; r < 24; r++) begin
            for (int i = 0; i < 64; i++) begin
                tbl[i] = (r % 2) ? int'({$random(seed)} % 4) - 2 : int'($signed(16'($random(seed))));
            end
            run_op({$random(seed)} % 3, {$random(seed)} % 64 + 1, {$random(seed)} % 400,
                800 + {$random(seed)} % 200);
        end
        conclude();
    end
endmodule

// File: dv/tmma_regmem.sv
// Behavioural data register memory on the far side of the unit
`timescale 1ns/1ps
module tmma_regmem (
    input wire logic clk,
    input wire logic rst,
    input wire logic rd_req,
    input wire logic [tmma_pkg::ADDR_W-1:0] rd_addr,
    output logic [tmma_pkg::DATA_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [tmma_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [tmma_pkg::DATA_W-1:0] wr_data
);
    // Only 1K words modelled; the bench keeps all addresses below that
    logic [tmma_pkg::DATA_W-1:0] mem [0:1023];
    // Read answers one cycle after the request and holds until the next one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 16'h0000;
        end else if (rd_req) begin
            rd_data <= mem[rd_addr[9:0]];
        end
    end
    // Plain always so the bench may also preload tables directly
    always @(posedge clk) begin
        if (!rst && wr_en) begin
            mem[wr_addr[9:0]] <= wr_data;
        end
    end
endmodule
